// ===== dv/host_model.sv
/* Host computer model: random queries, mask writes and presets.
   Assumes sync active-high reset; commands change 2 ns after the edge. */
module host_model (
  input  wire logic        sys_clk,            // System clock
  input  wire logic        sys_rst,            // Keeps host quiet
  output logic             event_rd,           // Query strobe
  output logic             mask_wr,            // Mask write strobe
  output logic      [1:0]  reg_sel,            // Register selected
  output logic      [15:0] decimal_mask_value, // Mask pattern
  output logic             status_preset       // Preset strobe
);
  timeunit 1ns;
  timeprecision 100ps;
  integer seed = 32'h1225;
  logic   [31:0] pick;
  logic          quiet;
  initial {event_rd, mask_wr, status_preset, reg_sel, decimal_mask_value} = 21'h0;
  // New command after each edge; nothing while reset was seen
  always @(posedge sys_clk) begin
    quiet = sys_rst;
    #2;
    pick = $random(seed);
    event_rd = !quiet && pick[1:0] == 2'h0;
    mask_wr = !quiet && pick[3:2] == 2'h0;
    status_preset = !quiet && pick[9:4] == 6'h0;
    reg_sel = pick[11:10];
    decimal_mask_value = pick[13:12] == 2'h0 ? 16'h0 :
      pick[13:12] == 2'h1 ? 16'hffff : 16'($random(seed));
  end
endmodule : host_model

// ===== dv/status_bank_properties.sv
/* Port-level assertions for the status event bank.
   Assumes binding into the bank; everything runs on sys_clk. */
module status_bank_properties (
  input wire logic        sys_clk,              // Clock
  input wire logic        sys_rst,              // Sync reset
  input wire logic        clk_en,               // Run enable
  input wire logic        ref_junction_invalid, // Junction fault
  input wire logic        cal_const_bad,        // Bad constant
  input wire logic        idle_state,           // Idle
  input wire logic        event_rd,             // Query
  input wire logic        mask_wr,              // Mask write
  input wire logic [1:0]  reg_sel,              // Select
  input wire logic [15:0] decimal_mask_value,   // Mask pattern
  input wire logic        status_preset,        // Preset
  input wire logic [15:0] rd_data,              // Answer
  input wire logic        rd_valid,             // Answer strobe
  input wire logic        activity_summary,     // Activity summary
  input wire logic        fault_indicator,      // Fault lamp
  input wire logic        cal_default_used      // Default constant
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  // Query answer and refusal
  query_answer_a: assert property (clk_en && event_rd && reg_sel != 2'h3 |=> rd_valid)
    else $error("query not answered");
  refused_sel_a: assert property (clk_en && event_rd && reg_sel == 2'h3 |=> !rd_valid)
    else $error("unknown select answered");
  // Read clears, unused bits read zero
  read_clear_a: assert property ((clk_en && event_rd && reg_sel == 2'h2 && !idle_state)
    ##1 (clk_en && event_rd && reg_sel == 2'h2) |=> !rd_data[10])
    else $error("event bit survived read");
  unused_zero_a: assert property ($past(clk_en && event_rd && reg_sel == 2'h0)
    |-> (rd_data & ~status_bank_pkg::READING_MASK) == 16'h0)
    else $error("unused bit read as one");
  // Fault lamp and calibration default
  fault_lamp_a: assert property (clk_en && ref_junction_invalid |=> fault_indicator)
    else $error("fault lamp stayed dark");
  cal_default_a: assert property (clk_en && cal_const_bad |=> cal_default_used && fault_indicator)
    else $error("bad constant not flagged");
  // Masks
  preset_clear_a: assert property (clk_en && status_preset |=> !activity_summary)
    else $error("summary after preset");
  mask_full_a: assert property (clk_en && mask_wr && !status_preset && reg_sel == 2'h2 &&
    decimal_mask_value == 16'hffff && idle_state |=> activity_summary)
    else $error("full mask did not pass event");
  cover property (clk_en && event_rd && reg_sel == 2'h1);
  cover property (clk_en && status_preset);
  cover property (clk_en && mask_wr && decimal_mask_value == 16'hffff);
endmodule : status_bank_properties

bind instrument_status_event_bank status_bank_properties CHK (.*);

// ===== dv/tb_top.sv
/* Self-checking bench: random conditions and host traffic against a model.
   Assumes the bank, its package and the host model. */
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic sys_clk = 1'b0, sys_rst = 1'b1, clk_en, reading_over_range, below_first_lower_limit;
  logic above_first_upper_limit, below_second_lower_limit, above_second_upper_limit;
  logic new_reading_ready, ref_junction_invalid, cal_const_bad, cal_done_ok, self_trim_invalid;
  logic self_trim_ok, calibrating, measuring, trig_waiting, filter_settled, idle_state;
  logic event_rd, mask_wr, status_preset, rd_valid, reading_summary, fault_summary;
  logic activity_summary, fault_indicator, cal_default_used, cf, tf, exp_rv;
  logic [1:0]  reg_sel;
  logic [9:0]  store_count, store_capacity;
  logic [15:0] decimal_mask_value, rd_data, exp_rd, ev [3], en [3], st [3];
  integer seed = 32'h1225;
  integer errors = 0;
  integer checks = 0;
  always #10 sys_clk = ~sys_clk;
  instrument_status_event_bank DUT (.*);
  host_model HOST (.*);
  // Sparse random conditions
  task automatic drive;
    {reading_over_range, below_first_lower_limit, above_first_upper_limit,
     below_second_lower_limit, above_second_upper_limit, new_reading_ready,
     ref_junction_invalid, calibrating, measuring, trig_waiting, filter_settled,
     idle_state} = 12'($random(seed) & $random(seed));
    {cal_const_bad, cal_done_ok, self_trim_invalid, self_trim_ok} = 4'(1 << ($random(seed) & 15));
    clk_en = ($random(seed) & 7) != 0;
    store_capacity = 10'($random(seed) & 15);
    store_count = 10'($random(seed) & 15);
  endtask : drive
  task automatic cmp_word(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask : cmp_word
  task automatic cmp_flag(input logic got, input logic exp);
    cmp_word({15'h0, got}, {15'h0, exp});
  endtask : cmp_flag
  task automatic tally_and_finish;
    if (errors == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : tally_and_finish
  // Reference model, updated at each edge and compared at the falling edge
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      ev = '{default: 16'h0};
      en = '{default: 16'h0};
      {cf, tf, exp_rv, exp_rd} = 19'h0;
    end else if (clk_en) begin
      cf = cal_const_bad | (cf & ~cal_done_ok);
      tf = self_trim_invalid | (tf & ~self_trim_ok);
      st[0] = {6'h0, store_capacity != 0 && store_count >= store_capacity,
        store_capacity != 0 && 2 * store_count >= store_capacity, store_count >= 2, 1'b0,
        new_reading_ready, above_second_upper_limit, below_second_lower_limit,
        above_first_upper_limit, below_first_lower_limit, reading_over_range};
      st[1] = {6'h0, tf, cf, 3'h0, ref_junction_invalid, 4'h0};
      st[2] = {5'h0, idle_state, 1'b0, filter_settled, 2'h0, trig_waiting, measuring, 3'h0,
        calibrating};
      exp_rv = event_rd && reg_sel != 2'h3;
      if (event_rd) exp_rd = (reg_sel == 2'h3) ? 16'h0 : ev[reg_sel];
      if (exp_rv) ev[reg_sel] = 16'h0;
      for (int i = 0; i < 3; i++) ev[i] |= st[i];
      if (status_preset) en = '{default: 16'h0};
      else if (mask_wr && reg_sel != 2'h3) en[reg_sel] = decimal_mask_value;
    end
    @(negedge sys_clk);
    cmp_flag(rd_valid, exp_rv);
    cmp_word(rd_data, exp_rd);
    cmp_flag(reading_summary, |(ev[0] & en[0]));
    cmp_flag(fault_summary, |(ev[1] & en[1]));
    cmp_flag(activity_summary, |(ev[2] & en[2]));
    cmp_flag(fault_indicator, |ev[1]);
    cmp_flag(cal_default_used, cf);
  end
  // Main sequence with a reset in mid-run
  initial begin
    drive();
    repeat (16) @(posedge sys_clk);
    for (int i = 0; i < 4000; i++) begin
      #2 sys_rst = i inside {[2000:2002]};
      drive();
      @(posedge sys_clk);
    end
    tally_and_finish();
  end
  // Watchdog at about two and a half times the expected run
  initial begin
    #200000;
    errors++;
    tally_and_finish();
  end
endmodule : tb_top

// ===== hw/instrument_status_event_bank.sv
/*
  Status event register bank: three sticky 16-bit event registers with
  clear-on-read, three enable masks, summary outputs and fault indicator.
  Assumes condition inputs come from logic on sys_clk; the host command
  decoder issues single-cycle read, mask-write and preset strobes.
*/
// Contract
// - Reading an event register clears all its bits; a bit raised in the same cycle stays set.
// - Query returns register value; each set bit is a one in binary.
// - Bit 0 of reading events sets on over-range reading.
// - Bits 1 and 2 set on first lower and upper limit violations.
// - Bits 3 and 4 set on second lower and upper limit violations.
// - Bit 5 sets when a reading is acquired and processed.
// - Bit 7 sets when trace store holds two or more readings.
// - Bit 8 sets when trace store reaches half capacity.
// - Bit 9 sets when trace store has no free locations.
// - Fault bit 4 sets on invalid reference junction measurement.
// - Fault bit 8 holds from bad constant until calibration succeeds.
// - Fault bit 9 holds from bad self-trim until later one succeeds.
// - Fault indicator is on while any fault event is present.
// - Activity bit 0 sets while calibrating.
// - Activity bit 4 sets while converting.
// - Activity bit 5 sets while waiting in trigger layer.
// - Activity bit 8 sets once averaging filter settles.
// - Activity bit 10 sets while idle.
// - Mask write loads the decimal value's pattern; 0 clears, 65535 fills.
// - Only enabled event bits drive the summary output.
// - Preset clears all three masks and nothing else.
module instrument_status_event_bank (
  input  wire logic        sys_clk,                  // System clock, 50 MHz
  input  wire logic        sys_rst,                  // Synchronous reset, active high
  input  wire logic        clk_en,                   // Freezes all state while low
  input  wire logic        reading_over_range,       // Reading beyond range
  input  wire logic        below_first_lower_limit,  // Reading below limit 1 low
  input  wire logic        above_first_upper_limit,  // Reading above limit 1 high
  input  wire logic        below_second_lower_limit, // Reading below limit 2 low
  input  wire logic        above_second_upper_limit, // Reading above limit 2 high
  input  wire logic        new_reading_ready,        // Pulse: reading processed
  input  wire logic [9:0]  store_count,              // Trace store occupancy
  input  wire logic [9:0]  store_capacity,           // Trace store size
  input  wire logic        ref_junction_invalid,     // Bad reference junction
  input  wire logic        cal_const_bad,            // Pulse: bad constant at power-up
  input  wire logic        cal_done_ok,              // Pulse: calibration succeeded
  input  wire logic        self_trim_invalid,        // Pulse: self-trim failed
  input  wire logic        self_trim_ok,             // Pulse: self-trim succeeded
  input  wire logic        calibrating,              // Calibration in progress
  input  wire logic        measuring,                // Conversion in progress
  input  wire logic        trig_waiting,             // Waiting in trigger layer
  input  wire logic        filter_settled,           // Averaging filter settled
  input  wire logic        idle_state,               // Instrument idle
  input  wire logic        event_rd,                 // Pulse: event register query
  input  wire logic        mask_wr,                  // Pulse: mask write
  input  wire logic [1:0]  reg_sel,                  // Register selected
  input  wire logic [15:0] decimal_mask_value,       // Mask pattern from host
  input  wire logic        status_preset,            // Pulse: clear all masks
  output logic      [15:0] rd_data,                  // Query answer
  output logic             rd_valid,                 // Pulse: answer valid
  output logic             reading_summary,          // Enabled reading event
  output logic             fault_summary,            // Enabled fault event
  output logic             activity_summary,         // Enabled activity event
  output logic             fault_indicator,          // Front fault lamp
  output logic             cal_default_used          // Default constant in use
);

  // Latched event registers and their next values
  logic [15:0] reading_ev;            // Reading events
  logic [15:0] fault_ev;              // Fault events
  logic [15:0] activity_ev;           // Activity events
  logic [15:0] next_reading_ev;       // Next reading events
  logic [15:0] next_fault_ev;         // Next fault events
  logic [15:0] next_activity_ev;      // Next activity events

  // Enable masks and their next values
  logic [15:0] reading_en;            // Reading enable mask
  logic [15:0] fault_en;              // Fault enable mask
  logic [15:0] activity_en;           // Activity enable mask
  logic [15:0] next_reading_en;       // Next reading mask
  logic [15:0] next_fault_en;         // Next fault mask
  logic [15:0] next_activity_en;      // Next activity mask

  // Persistent calibration faults
  logic        cal_bad;               // Default constant in use
  logic        trim_bad;              // Last self-trim failed
  logic        next_cal_bad;          // Next constant state
  logic        next_trim_bad;         // Next self-trim state

  // Query answer and status outputs
  logic [15:0] next_rd_data;          // Next query answer
  logic        next_rd_valid;         // Next answer strobe
  logic        next_reading_summary;  // Next reading summary
  logic        next_fault_summary;    // Next fault summary
  logic        next_activity_summary; // Next activity summary
  logic        next_fault_indicator;  // Next fault lamp
  logic        next_cal_default_used; // Next default flag

  // Events raised this cycle and decoded query strobes
  logic [15:0] reading_set;           // Reading events now
  logic [15:0] fault_set;             // Fault events now
  logic [15:0] activity_set;          // Activity events now
  logic [10:0] half_x2;               // Twice the occupancy, no overflow
  logic        reading_clr;           // Query of reading events
  logic        fault_clr;             // Query of fault events
  logic        activity_clr;          // Query of activity events
  logic        query_known;           // Query names a register

  // Sticky update: set wins over the read clear
  function automatic logic [15:0] latch_ev(input logic [15:0] cur,
                                           input logic [15:0] set,
                                           input logic        clr,
                                           input logic [15:0] mask);
    latch_ev = ((clr ? 16'h0000 : cur) | set) & mask;
  endfunction : latch_ev

  // Query strobe aimed at one register select
  function automatic logic query_hits(input logic       rd,
                                      input logic [1:0] sel,
                                      input logic [1:0] code);
    query_hits = rd && (sel == code);
  endfunction : query_hits

  // Any enabled event bit present
  function automatic logic any_enabled(input logic [15:0] ev,
                                       input logic [15:0] en);
    any_enabled = |(ev & en);
  endfunction : any_enabled

  // Query decode: which register a read strobe clears
  always_comb begin
    reading_clr  = query_hits(event_rd, reg_sel, status_bank_pkg::SEL_READING);
    fault_clr    = query_hits(event_rd, reg_sel, status_bank_pkg::SEL_FAULT);
    activity_clr = query_hits(event_rd, reg_sel, status_bank_pkg::SEL_ACTIVITY);
    query_known  = reading_clr || fault_clr || activity_clr;
  end

  // Event sources, mapped onto bit positions
  always_comb begin
    half_x2 = {store_count, 1'b0};
    reading_set = 16'h0000;
    reading_set[status_bank_pkg::BIT_OVER_RANGE]  = reading_over_range;
    reading_set[status_bank_pkg::BIT_LOW1]        = below_first_lower_limit;
    reading_set[status_bank_pkg::BIT_HIGH1]       = above_first_upper_limit;
    reading_set[status_bank_pkg::BIT_LOW2]        = below_second_lower_limit;
    reading_set[status_bank_pkg::BIT_HIGH2]       = above_second_upper_limit;
    reading_set[status_bank_pkg::BIT_READY]       = new_reading_ready;
    reading_set[status_bank_pkg::BIT_STORE_AVAIL] =
      store_count >= status_bank_pkg::STORE_AVAIL;
    reading_set[status_bank_pkg::BIT_STORE_HALF]  =
      (store_capacity != 10'h000) && (half_x2 >= {1'b0, store_capacity});
    reading_set[status_bank_pkg::BIT_STORE_FULL]  =
      (store_capacity != 10'h000) && (store_count >= store_capacity);
    fault_set = 16'h0000;
    fault_set[status_bank_pkg::BIT_REF_JUNCTION] = ref_junction_invalid;
    fault_set[status_bank_pkg::BIT_CAL_CONST]    = next_cal_bad;
    fault_set[status_bank_pkg::BIT_SELF_TRIM]    = next_trim_bad;
    activity_set = 16'h0000;
    activity_set[status_bank_pkg::BIT_CALIBRATING] = calibrating;
    activity_set[status_bank_pkg::BIT_MEASURING]   = measuring;
    activity_set[status_bank_pkg::BIT_TRIG_WAIT]   = trig_waiting;
    activity_set[status_bank_pkg::BIT_FILT_SETTLE] = filter_settled;
    activity_set[status_bank_pkg::BIT_IDLE]        = idle_state;
  end

  // Persistent calibration fault conditions
  always_comb begin
    next_cal_bad  = cal_bad;
    next_trim_bad = trim_bad;
    if (cal_done_ok) begin
      next_cal_bad = 1'b0;
    end
    if (cal_const_bad) begin
      next_cal_bad = 1'b1;
    end
    if (self_trim_ok) begin
      next_trim_bad = 1'b0;
    end
    if (self_trim_invalid) begin
      next_trim_bad = 1'b1;
    end
  end

  // Persistent calibration fault registers
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      cal_bad  <= 1'b0;
      trim_bad <= 1'b0;
    end else if (clk_en) begin
      cal_bad  <= next_cal_bad;
      trim_bad <= next_trim_bad;
    end
  end

  // Reading events: read clear, then this cycle's sets
  always_comb begin
    next_reading_ev = latch_ev(reading_ev, reading_set, reading_clr,
                               status_bank_pkg::READING_MASK);
  end

  // Reading event register
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      reading_ev <= status_bank_pkg::EVENT_RESET;
    end else if (clk_en) begin
      reading_ev <= next_reading_ev;
    end
  end

  // Fault events: persistent faults re-raise their bit each cycle
  always_comb begin
    next_fault_ev = latch_ev(fault_ev, fault_set, fault_clr,
                             status_bank_pkg::FAULT_MASK);
  end

  // Fault event register
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      fault_ev <= status_bank_pkg::EVENT_RESET;
    end else if (clk_en) begin
      fault_ev <= next_fault_ev;
    end
  end

  // Activity events: read clear, then this cycle's sets
  always_comb begin
    next_activity_ev = latch_ev(activity_ev, activity_set, activity_clr,
                                status_bank_pkg::ACTIVITY_MASK);
  end

  // Activity event register
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      activity_ev <= status_bank_pkg::EVENT_RESET;
    end else if (clk_en) begin
      activity_ev <= next_activity_ev;
    end
  end

  // Enable masks: preset beats a mask write in the same cycle
  always_comb begin
    next_reading_en  = reading_en;
    next_fault_en    = fault_en;
    next_activity_en = activity_en;
    if (status_preset) begin
      next_reading_en  = status_bank_pkg::ENABLE_RESET;
      next_fault_en    = status_bank_pkg::ENABLE_RESET;
      next_activity_en = status_bank_pkg::ENABLE_RESET;
    end else if (mask_wr) begin
      unique case (reg_sel)
        status_bank_pkg::SEL_READING:  next_reading_en  = decimal_mask_value;
        status_bank_pkg::SEL_FAULT:    next_fault_en    = decimal_mask_value;
        status_bank_pkg::SEL_ACTIVITY: next_activity_en = decimal_mask_value;
        default: ;
      endcase
    end
  end

  // Enable mask registers
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      reading_en  <= status_bank_pkg::ENABLE_RESET;
      fault_en    <= status_bank_pkg::ENABLE_RESET;
      activity_en <= status_bank_pkg::ENABLE_RESET;
    end else if (clk_en) begin
      reading_en  <= next_reading_en;
      fault_en    <= next_fault_en;
      activity_en <= next_activity_en;
    end
  end

  // Query answer: old contents go out, an unknown select answers zero
  always_comb begin
    next_rd_valid = query_known;
    next_rd_data  = rd_data;
    if (event_rd) begin
      unique case (reg_sel)
        status_bank_pkg::SEL_READING:  next_rd_data = reading_ev;
        status_bank_pkg::SEL_FAULT:    next_rd_data = fault_ev;
        status_bank_pkg::SEL_ACTIVITY: next_rd_data = activity_ev;
        default:                       next_rd_data = 16'h0000;
      endcase
    end
  end

  // Query answer registers; the word stands until the next query
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      rd_data  <= 16'h0000;
      rd_valid <= 1'b0;
    end else if (clk_en) begin
      rd_data  <= next_rd_data;
      rd_valid <= next_rd_valid;
    end
  end

  // Summaries, lamp and default flag follow the next register contents
  always_comb begin
    next_reading_summary  = any_enabled(next_reading_ev, next_reading_en);
    next_fault_summary    = any_enabled(next_fault_ev, next_fault_en);
    next_activity_summary = any_enabled(next_activity_ev, next_activity_en);
    next_fault_indicator  = |next_fault_ev;
    next_cal_default_used = next_cal_bad;
  end

  // Registered status outputs
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      reading_summary  <= 1'b0;
      fault_summary    <= 1'b0;
      activity_summary <= 1'b0;
      fault_indicator  <= 1'b0;
      cal_default_used <= 1'b0;
    end else if (clk_en) begin
      reading_summary  <= next_reading_summary;
      fault_summary    <= next_fault_summary;
      activity_summary <= next_activity_summary;
      fault_indicator  <= next_fault_indicator;
      cal_default_used <= next_cal_default_used;
    end
  end

endmodule : instrument_status_event_bank

// ===== pkg/status_bank_pkg.sv
/*
  Constants for the instrument status event bank: register selects,
  bit positions of each event register, implemented-bit masks, reset values.
  Assumes a host command decoder that turns status commands into strobes.
*/
package status_bank_pkg;

  // Register select codes on the host command port
  localparam logic [1:0] SEL_READING  = 2'h0;
  localparam logic [1:0] SEL_FAULT    = 2'h1;
  localparam logic [1:0] SEL_ACTIVITY = 2'h2;

  // Reading event bit positions
  localparam int BIT_OVER_RANGE  = 0;
  localparam int BIT_LOW1        = 1;
  localparam int BIT_HIGH1       = 2;
  localparam int BIT_LOW2        = 3;
  localparam int BIT_HIGH2       = 4;
  localparam int BIT_READY       = 5;
  localparam int BIT_STORE_AVAIL = 7;
  localparam int BIT_STORE_HALF  = 8;
  localparam int BIT_STORE_FULL  = 9;

  // Fault event bit positions
  localparam int BIT_REF_JUNCTION = 4;
  localparam int BIT_CAL_CONST    = 8;
  localparam int BIT_SELF_TRIM    = 9;

  // Activity event bit positions
  localparam int BIT_CALIBRATING = 0;
  localparam int BIT_MEASURING   = 4;
  localparam int BIT_TRIG_WAIT   = 5;
  localparam int BIT_FILT_SETTLE = 8;
  localparam int BIT_IDLE        = 10;

  // Implemented bits of each event register
  localparam logic [15:0] READING_MASK  = 16'h03bf;
  localparam logic [15:0] FAULT_MASK    = 16'h0310;
  localparam logic [15:0] ACTIVITY_MASK = 16'h0531;

  // Values after reset
  localparam logic [15:0] EVENT_RESET  = 16'h0000;
  localparam logic [15:0] ENABLE_RESET = 16'h0000;

  // Trace store occupancy width and thresholds
  localparam int          STORE_W     = 10;
  localparam logic [9:0]  STORE_AVAIL = 10'h002;

endpackage : status_bank_pkg
